/* File: hdl/gfm_mapper.sv */
// General-purpose pin function mapper top module
`include "gfm_defs.svh"

module gfm_mapper
  import gfm_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                reset_in,
  // Pin
  input  wire logic                pin_in,
  output      logic                pin_out,
  output      logic                pin_oe_out,
  // Pin configuration register bits
  input  wire logic [15:0]         pin_config_in,
  // Device status
  input  wire logic                memory_programming_busy_in,
  input  wire logic                channel_one_busy_in,
  input  wire logic                channel_one_window_result_in,
  input  wire logic                channel_zero_window_result_in,
  // Software trigger requests
  input  wire logic [CHANNELS-1:0] sw_start_func_in,
  input  wire logic [CHANNELS-1:0] sw_margin_low_in,
  input  wire logic [CHANNELS-1:0] sw_margin_high_in,
  input  wire logic                sw_nvm_prog_in,
  // Write qualification
  input  wire logic                reg_write_in,
  input  wire logic                reg_write_unlock_in,
  input  wire logic                reg_write_reset_i2c_in,
  output      logic                reg_write_ok_out,
  output      logic                nvm_prog_out,
  // Actions
  output      logic [CHANNELS-1:0] start_func_out,
  output      logic [CHANNELS-1:0] margin_low_out,
  output      logic [CHANNELS-1:0] margin_high_out,
  output      logic                device_reset_out
);

  // --------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------
  logic                input_mode_enable;
  logic                output_mode_enable;
  logic [3:0]          input_function_code;
  logic [3:0]          output_function_code;
  logic [CHANNELS-1:0] input_channel_select;

  assign input_mode_enable    = pin_config_in[`GFM_CFG_IN_EN];
  assign output_mode_enable   = pin_config_in[`GFM_CFG_OUT_EN];
  assign input_function_code  = pin_config_in[`GFM_CFG_IN_LSB +: 4];
  assign output_function_code = pin_config_in[`GFM_CFG_OUT_LSB +: 4];
  assign input_channel_select = pin_config_in[`GFM_CFG_SEL_LSB +: CHANNELS];

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  gfm_state_type st_r;
  gfm_state_type st_nxt;

  logic pin_s;
  logic rise;
  logic fall;
  logic boot;
  logic in_fg;
  logic in_mg;
  logic in_nv;
  logic status_sel;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[0], pin_in};
    pin_s = st_r.sync[1];
    st_nxt.pin_prev = pin_s;
    boot = (st_r.phase == GFM_PRIME);
    rise = (pin_s & ~st_r.pin_prev) | (boot & pin_s);
    fall = (~pin_s & st_r.pin_prev) | (boot & ~pin_s);
    unique case (st_r.phase)
      GFM_BOOT:  st_nxt.phase = GFM_PRIME;
      GFM_PRIME: st_nxt.phase = GFM_RUN;
      GFM_RUN:   st_nxt.phase = GFM_RUN;
      default:   st_nxt.phase = GFM_RUN;
    endcase
    in_fg = input_mode_enable && input_function_code == `GFM_IN_FUNC_GEN;
    in_mg = input_mode_enable && input_function_code == `GFM_IN_MARGIN;
    in_nv = input_mode_enable && input_function_code == `GFM_IN_NVM_GATE;
    st_nxt.start_func = '0;
    st_nxt.mar_lo = '0;
    st_nxt.mar_hi = '0;
    st_nxt.dev_reset = 1'b0;
    // Pin actions; other codes fall through untouched
    if (st_r.phase != GFM_BOOT && input_mode_enable)
    begin
      unique case (input_function_code)
        `GFM_IN_FUNC_GEN:
          if (rise)
            st_nxt.start_func = input_channel_select;
        `GFM_IN_MARGIN:
        begin
          if (fall)
            st_nxt.mar_lo = input_channel_select;
          if (rise)
            st_nxt.mar_hi = input_channel_select;
        end
        `GFM_IN_RESET:
        begin
          if (fall && !boot)
            st_nxt.rst_pend = 1'b1;
          if (rise && st_r.rst_pend)
          begin
            st_nxt.rst_pend = 1'b0;
            st_nxt.dev_reset = 1'b1;
          end
        end
        `GFM_IN_NVM_GATE:
        begin
          if (fall)
            st_nxt.nvm_allow = 1'b1;
          if (rise)
            st_nxt.nvm_allow = 1'b0;
        end
        `GFM_IN_REG_GATE:
        begin
          if (fall)
            st_nxt.reg_allow = 1'b1;
          if (rise)
            st_nxt.reg_allow = 1'b0;
        end
        default:
          st_nxt.rst_pend = st_r.rst_pend;
      endcase
    end
    // Software triggers only where the pin does not own the function
    if (!in_fg)
      st_nxt.start_func = st_r.phase == GFM_BOOT ? '0 : sw_start_func_in;
    if (!in_mg)
    begin
      st_nxt.mar_lo = sw_margin_low_in;
      st_nxt.mar_hi = sw_margin_high_in;
    end
    // Status selection
    unique case (output_function_code)
      `GFM_OUT_MEMORY_PROGRAMMING_BUSY: status_sel = memory_programming_busy_in;
      `GFM_OUT_CH1_BUSY: status_sel = channel_one_busy_in;
      `GFM_OUT_CH1_WIN:  status_sel = channel_one_window_result_in;
      `GFM_OUT_CH0_WIN:  status_sel = channel_zero_window_result_in;
      default:           status_sel = 1'b0;
    endcase
    st_nxt.pin_oe = output_mode_enable & ~input_mode_enable;
    st_nxt.pin_out = st_nxt.pin_oe & status_sel;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_r <= '0;
      st_r.sync <= `GFM_SYNC_RST;
      st_r.pin_prev <= 1'b1;
      st_r.phase <= GFM_BOOT;
      st_r.nvm_allow <= 1'b1;
      st_r.reg_allow <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign pin_out          = st_r.pin_out;
  assign pin_oe_out       = st_r.pin_oe;
  assign start_func_out   = st_r.start_func;
  assign margin_low_out   = st_r.mar_lo;
  assign margin_high_out  = st_r.mar_hi;
  assign device_reset_out = st_r.dev_reset;
  assign nvm_prog_out     = in_nv ? (sw_nvm_prog_in & st_r.nvm_allow)
                                  : sw_nvm_prog_in;
  assign reg_write_ok_out = reg_write_in &
                            (st_r.reg_allow | reg_write_unlock_in |
                             reg_write_reset_i2c_in);

endmodule : gfm_mapper

/* File: hdl/gfm_defs.svh */
// Constants of the general-purpose pin function mapper
//
// What this block does
// - Code 1001: rising pin edge starts waveform generation on selected channels.
// - Code 1010: falling edge applies margin-low, rising edge margin-high.
// - Code 1011: low pulse resets device at its rising end; lone rising edge ignored; mapping kept in memory.
// - Code 1100: falling edge allows memory programming, rising edge blocks it.
// - Code 1101: falling edge re-enables writes to the register map.
// - Code 1101: rising edge blocks writes except unlock field and two-wire reset.
// - Undefined input codes change nothing.
// - Output mode drives status chosen by output code while input mode is off; other codes not applicable.
// - Channel functions act only on channels in the channel-select field.
// - A mapped start or margin function disables the matching software trigger bits; code 1100 only gates the programming request.
// - After power-up the synchronizer reset level (high) is taken once as the pin level and its rising-edge command executed.
`ifndef GFM_DEFS_SVH
`define GFM_DEFS_SVH

// ----------------------------------------------------------------------
// Input function codes
// ----------------------------------------------------------------------
`define GFM_IN_FUNC_GEN   4'h9
`define GFM_IN_MARGIN     4'ha
`define GFM_IN_RESET      4'hb
`define GFM_IN_NVM_GATE   4'hc
`define GFM_IN_REG_GATE   4'hd

// ----------------------------------------------------------------------
// Output function codes
// ----------------------------------------------------------------------
`define GFM_OUT_MEMORY_PROGRAMMING_BUSY  4'h1
`define GFM_OUT_CH1_BUSY  4'h4
`define GFM_OUT_CH1_WIN   4'h8
`define GFM_OUT_CH0_WIN   4'hb

// ----------------------------------------------------------------------
// Pin configuration field positions
// ----------------------------------------------------------------------
`define GFM_CFG_IN_EN     0
`define GFM_CFG_IN_LSB    1
`define GFM_CFG_SEL_LSB   5
`define GFM_CFG_OUT_LSB   9
`define GFM_CFG_OUT_EN    13

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GFM_SYNC_RST      2'h3

`endif

/* File: hdl/gfm_pkg.sv */
// Types of the general-purpose pin function mapper
package gfm_pkg;

  typedef enum logic [1:0]
  {
    GFM_BOOT = 2'b00,
    GFM_PRIME = 2'b01,
    GFM_RUN = 2'b11
  } gfm_phase_type;

  typedef struct packed
  {
    logic [1:0]    sync;
    logic          pin_prev;
    gfm_phase_type phase;
    logic          nvm_allow;
    logic          reg_allow;
    logic          rst_pend;
    logic [1:0]    start_func;
    logic [1:0]    mar_lo;
    logic [1:0]    mar_hi;
    logic          dev_reset;
    logic          pin_out;
    logic          pin_oe;
  } gfm_state_type;

endpackage : gfm_pkg

/* File: tb/gfm_mapper_properties.sv */
// Port checks of the pin function mapper
module gfm_mapper_properties #(parameter int CHANNELS = 2)
(
  // Clock, reset and pin
  input wire logic                clk_sys_in, reset_in, pin_in,
  input wire logic                pin_out, pin_oe_out,
  // Configuration and status
  input wire logic [15:0]         pin_config_in,
  input wire logic                memory_programming_busy_in, reg_write_in,
  input wire logic                reg_write_unlock_in, reg_write_reset_i2c_in,
  // Outcomes
  input wire logic                reg_write_ok_out, device_reset_out,
  input wire logic [CHANNELS-1:0] start_func_out
);
  wire logic [3:0]          code = pin_config_in[0] ? pin_config_in[4:1] : 4'h0;
  wire logic [CHANNELS-1:0] sel  = pin_config_in[5 +: CHANNELS];
  wire logic                oe_want = pin_config_in[13] & ~pin_config_in[0];
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_oe_direction: assert property (
    !$past(reset_in) |-> pin_oe_out == $past(oe_want))
    else $error("pin enable wrong");
  a_out_busy: assert property (
    !$past(reset_in) && pin_oe_out && $past(pin_config_in[12:9]) == 4'h1
    |-> pin_out == $past(memory_programming_busy_in))
    else $error("pin out not busy flag");
  a_ok_exempt: assert property (
    reg_write_in && (reg_write_unlock_in || reg_write_reset_i2c_in)
    |-> reg_write_ok_out) else $error("exempt write refused");
  a_ok_needs_wr: assert property (
    !reg_write_in |-> !reg_write_ok_out) else $error("write ok unasked");
  a_start_once: assert property (
    |start_func_out |=> start_func_out == '0) else $error("start too long");
  a_start_sel: assert property (
    code == 4'h9 |-> (start_func_out & ~sel) == '0)
    else $error("start on unselected channel");
  a_rst_once: assert property (
    device_reset_out |=> !device_reset_out) else $error("reset too long");
  a_rst_cause: assert property (
    device_reset_out && code == 4'hb |-> $past(pin_in, 2))
    else $error("reset without rising end");
endmodule : gfm_mapper_properties

bind gfm_mapper gfm_mapper_properties #(.CHANNELS(CHANNELS)) i_props
(
  .clk_sys_in, .reset_in, .pin_in, .pin_out, .pin_oe_out, .pin_config_in,
  .memory_programming_busy_in, .reg_write_in, .reg_write_unlock_in,
  .reg_write_reset_i2c_in, .reg_write_ok_out, .device_reset_out,
  .start_func_out
);

/* File: tb/gfm_pin_host.sv */
// Model of the controller that drives the pin from outside
module gfm_pin_host
(
  input  wire logic clk_in, dev_oe_in, dev_level_in,
  output      logic pin_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic level_r = 1'h1;
  // Firm level always, device drive wins when enabled
  assign pin_level_out = dev_oe_in ? dev_level_in : level_r;
  task automatic drive(input logic v);
  begin
    @(negedge clk_in);
    level_r = v;
  end
  endtask : drive
endmodule : gfm_pin_host

/* File: tb/gpio_function_mapper_bench.sv */
// Self-checking bench of the pin function mapper
module gpio_function_mapper_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in, reset_in, pin_in, pin_out, pin_oe_out, ok, nvm, dev_rst;
  logic sw_nvm, wr, unlock, i2c;
  logic [15:0] cfg;
  logic [3:0] status;
  logic [1:0] sw_start, start, mlo, mhi;
  logic [6:0] got;
  int error_cnt, num_checks;
  wire logic [6:0] act = {start, mlo, mhi, dev_rst};
  logic [19:0] steps [14] = '{20'h33_0_00, 20'h33_1_20, 20'h55_0_10,
    20'h55_1_04, 20'h17_0_00, 20'h17_1_01, 20'h01_0_00, 20'h01_1_00,
    20'h1f_0_00, 20'h1f_1_00, 20'h32_0_00, 20'h32_1_00, 20'h73_0_00,
    20'h73_1_60};
  logic [3:0] ocode [4] = '{4'h1, 4'h4, 4'h8, 4'hb};
  gfm_mapper i_dut
  (
    .clk_sys_in, .reset_in, .pin_in, .pin_out, .pin_oe_out,
    .pin_config_in(cfg), .memory_programming_busy_in(status[3]),
    .channel_one_busy_in(status[2]),
    .channel_one_window_result_in(status[1]),
    .channel_zero_window_result_in(status[0]),
    .sw_start_func_in(sw_start), .sw_margin_low_in(2'h0),
    .sw_margin_high_in(2'h0), .sw_nvm_prog_in(sw_nvm), .reg_write_in(wr),
    .reg_write_unlock_in(unlock), .reg_write_reset_i2c_in(i2c),
    .reg_write_ok_out(ok), .nvm_prog_out(nvm), .start_func_out(start),
    .margin_low_out(mlo), .margin_high_out(mhi), .device_reset_out(dev_rst)
  );
  gfm_pin_host i_host (.clk_in(clk_sys_in), .dev_oe_in(pin_oe_out),
    .dev_level_in(pin_out), .pin_level_out(pin_in));
  initial
  begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask : check
  // Gathers action pulses; several pulse cycles mark all ones
  task automatic collect;
  begin
    int hits;
    hits = 0;
    got = '0;
    repeat (6)
    begin
      @(negedge clk_sys_in);
      got |= act;
      hits += int'(act != '0);
    end
    if (hits > 1)
      got = 7'h7f;
  end
  endtask : collect
  task automatic close_out;
  begin
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : close_out
  initial
  begin
    #20000;
    error_cnt++;
    close_out;
  end
  initial
  begin
    reset_in = 1'h1;
    {cfg, status, sw_start, sw_nvm, wr, unlock, i2c} = '0;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'h0;
    repeat (4) @(negedge clk_sys_in);
    foreach (steps[i])
    begin
      cfg = {8'h00, steps[i][19:12]};
      i_host.drive(steps[i][8]);
      collect;
      check("actions", {1'h0, got}, steps[i][7:0]);
    end
    for (int k = 0; k < 2; k++)
    begin
      cfg = k ? 16'h0000 : 16'h0073;
      @(negedge clk_sys_in);
      sw_start = 2'h3;
      @(negedge clk_sys_in);
      check("software start", {1'h0, act}, k ? 8'h60 : 8'h00);
      sw_start = 2'h0;
    end
    cfg = 16'h0019;
    i_host.drive(1'h0);
    collect;
    sw_nvm = 1'h1;
    #1 check("program gate", {7'h0, nvm}, 8'h01);
    i_host.drive(1'h1);
    collect;
    check("program gate", {7'h0, nvm}, 8'h00);
    sw_nvm = 1'h0;
    cfg = 16'h001b;
    wr = 1'h1;
    i_host.drive(1'h0);
    i_host.drive(1'h1);
    collect;
    for (int k = 0; k < 3; k++)
    begin
      {unlock, i2c} = 2'(k);
      #1 check("write gate", {7'h0, ok}, {7'h0, k != 0});
    end
    {unlock, i2c} = 2'h0;
    i_host.drive(1'h0);
    collect;
    check("write gate", {7'h0, ok}, 8'h01);
    wr = 1'h0;
    foreach (ocode[i])
    begin
      cfg = 16'h2000 | (16'(ocode[i]) << 9);
      status = 4'(4'h8 >> i);
      repeat (2) @(negedge clk_sys_in);
      check("status pin", {6'h0, pin_oe_out, pin_out}, 8'h03);
      status = 4'h0;
      repeat (2) @(negedge clk_sys_in);
      check("status pin", {6'h0, pin_oe_out, pin_out}, 8'h02);
    end
    reset_in = 1'h1;
    cfg = 16'h0073;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'h0;
    collect;
    check("boot sample", {1'h0, got}, 8'h60);
    close_out;
  end
endmodule : gpio_function_mapper_bench
